/* File: verilog/lvdet_pkg.sv */
// Constants for the global control block of a four-channel downconverter:
// level detector, test input bus, sync strobes, self-test signature, FIFO order.
// Assumes one device clock and a synchronous parallel host port.
//
// Contract
// - Bit 21 ones-complements the detector input.
// - Bit 20 free-runs; else stop at interval end.
// - Bits 19:18 pick leak gain 1, 2^-8/12/16.
// - Mode 01 peak, 10 integrate; leaky integrator offered.
// - Interval field is count minus two, 2..65537.
// - Start write clears accumulator, restarts interval.
// - Interval end sets status bit 1.
// - Host test value usable as any sample source.
// - Test enable from bit 11 or strobe, bit 12.
// - Enable-address write makes one sample strobe.
// - Sync-out write gives one-clock sync pulse.
// - Sync-in write pulses out and feeds back.
// - Expected signature low, computed signature high.
// - Slot code low three bits give data type.
// - Low-half types put bits 7:0 above zeros.
// - Gated updates on enable; interpolated zeroes input.
// - Start address read returns 32-bit result.

package lvdet_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int NUM_CH = 4;

   localparam logic [15:0] ADDR_CONFIG     = 16'hF805;
   localparam logic [15:0] ADDR_START      = 16'hF806;
   localparam logic [15:0] ADDR_TEST_VALUE = 16'hF807;
   localparam logic [15:0] ADDR_TEST_EN    = 16'hF808;
   localparam logic [15:0] ADDR_SYNC_OUT   = 16'hF809;
   localparam logic [15:0] ADDR_SYNC_LOOP  = 16'hF80A;
   localparam logic [15:0] ADDR_SIGNATURE  = 16'hF80B;
   localparam logic [15:0] ADDR_ORDER_BASE = 16'hF820;
   localparam logic [15:0] ADDR_ORDER_LAST = 16'hF83F;

   localparam int CFG_W        = 22;
   localparam int CFG_CMPL_BIT = 21;
   localparam int CFG_FREE_BIT = 20;
   localparam int CFG_LEAK_LSB = 18;
   localparam int CFG_MODE_LSB = 16;
   localparam int STATUS_DONE_BIT = 1;
   localparam int CH_EN_BIT     = 11;
   localparam int CH_STROBE_BIT = 12;

   localparam logic [CFG_W-1:0] CFG_RESET  = 22'h000000;
   localparam logic [15:0]      TEST_RESET = 16'h0000;
   localparam logic [15:0]      SIG_RESET  = 16'h0000;
   localparam logic [4:0]       SLOT_RESET = 5'h00;

   localparam logic [1:0] MODE_LEAKY = 2'h0;
   localparam logic [1:0] MODE_PEAK  = 2'h1;
   localparam logic [1:0] MODE_INTEG = 2'h2;

   localparam logic [2:0] DT_I_HI   = 3'h0;
   localparam logic [2:0] DT_I_LO   = 3'h1;
   localparam logic [2:0] DT_Q_HI   = 3'h2;
   localparam logic [2:0] DT_Q_LO   = 3'h3;
   localparam logic [2:0] DT_MAG_HI = 3'h4;
   localparam logic [2:0] DT_MAG_LO = 3'h5;
   localparam logic [2:0] DT_PHASE  = 3'h6;
   localparam logic [2:0] DT_GAIN   = 3'h7;

endpackage : lvdet_pkg

/* File: verilog/lvdet_level_det.sv */
// Input level detector: formatting, leaky/peak/plain integration, interval count.
// Assumes start is a one-cycle pulse and sample inputs are on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module lvdet_level_det
   import lvdet_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [15:0] sample,
   input  wire logic        sample_en,
   input  wire logic        gated_interp_sel,
   input  wire logic [CFG_W-1:0] cfg,
   input  wire logic        start,
   output logic [31:0]      level_result,
   output logic             level_done
);
   typedef struct packed {
      logic [31:0] acc;
      logic [16:0] cnt;
      logic        expired;
      logic        done;
   } lvdet_ld_state_t;

   lvdet_ld_state_t s_q, s_d;
   logic [15:0] x_fmt, x, mag;
   logic [31:0] target;
   logic signed [32:0] diff, step;
   logic        upd, active;
   logic [1:0]  mode, leak;

   always_comb begin
      s_d    = s_q;
      mode   = cfg[CFG_MODE_LSB +: 2];
      leak   = cfg[CFG_LEAK_LSB +: 2];
      x_fmt  = cfg[CFG_CMPL_BIT] ? ~sample : sample;
      upd    = gated_interp_sel ? 1'b1 : sample_en;
      x      = (gated_interp_sel && !sample_en) ? 16'h0000 : x_fmt;
      mag    = x[15] ? 16'(~x + 16'h0001) : x;
      target = {mag, 16'h0000};
      diff   = $signed({1'b0, target}) - $signed({1'b0, s_q.acc});
      case (leak)
         2'h0:    step = diff;
         2'h1:    step = diff >>> 8;
         2'h2:    step = diff >>> 12;
         default: step = diff >>> 16;
      endcase
      // Free run keeps accumulating after the interval; the host may drop it to freeze the value.
      active = cfg[CFG_FREE_BIT] || !s_q.expired;
      if (start) begin
         s_d.acc     = 32'h00000000;
         s_d.cnt     = 17'h00000;
         s_d.expired = 1'b0;
         s_d.done    = 1'b0;
      end else if (upd) begin
         if (active) begin
            case (mode)
               MODE_LEAKY: s_d.acc = 32'($signed({1'b0, s_q.acc}) + step);
               MODE_PEAK:  s_d.acc = (target > s_q.acc) ? target : s_q.acc;
               MODE_INTEG: s_d.acc = s_q.acc + {16'h0000, mag};
               default:    s_d.acc = s_q.acc;
            endcase
         end
         if (!s_q.expired) begin
            if (s_q.cnt == ({1'b0, cfg[15:0]} + 17'h00001)) begin
               s_d.expired = 1'b1;
               s_d.done    = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt + 17'h00001;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_result = s_q.acc;
   assign level_done   = s_q.done;
endmodule : lvdet_level_det
`default_nettype wire

/* File: verilog/lvdet_fifo_order.sv */
// FIFO read-order table: 32 five-bit slot codes and the word they select.
// Assumes channel data words are stable on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module lvdet_fifo_order
   import lvdet_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        wr_en,
   input  wire logic [4:0]  wr_idx,
   input  wire logic [4:0]  wr_code,
   input  wire logic [4:0]  rd_idx,
   input  wire logic [3:0][23:0] ch_i,
   input  wire logic [3:0][23:0] ch_q,
   input  wire logic [3:0][23:0] ch_mag,
   input  wire logic [3:0][15:0] ch_phase,
   input  wire logic [3:0][15:0] ch_gain,
   input  wire logic [4:0]  fifo_slot,
   output logic [4:0]       rd_code,
   output logic [15:0]      fifo_word
);
   typedef struct packed {
      logic [31:0][4:0] slot;
      logic [15:0]      word;
   } lvdet_fo_state_t;

   lvdet_fo_state_t s_q, s_d;
   logic [4:0] code;
   logic [1:0] ch;

   always_comb begin
      s_d  = s_q;
      if (wr_en) begin
         s_d.slot[wr_idx] = wr_code;
      end
      code = s_q.slot[fifo_slot];
      ch   = code[4:3];
      case (code[2:0])
         DT_I_HI:   s_d.word = ch_i[ch][23:8];
         DT_I_LO:   s_d.word = {ch_i[ch][7:0], 8'h00};
         DT_Q_HI:   s_d.word = ch_q[ch][23:8];
         DT_Q_LO:   s_d.word = {ch_q[ch][7:0], 8'h00};
         DT_MAG_HI: s_d.word = ch_mag[ch][23:8];
         DT_MAG_LO: s_d.word = {ch_mag[ch][7:0], 8'h00};
         DT_PHASE:  s_d.word = ch_phase[ch];
         default:   s_d.word = ch_gain[ch];
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_code   = s_q.slot[rd_idx];
   assign fifo_word = s_q.word;
endmodule : lvdet_fifo_order
`default_nettype wire

/* File: verilog/lvdet_top.sv */
// Global control register bank: detector config and start, test input bus,
// sync strobes, self-test signature and FIFO read order.
// Assumes the host port is synchronous to ref_clk; the sync input is a pin.
`timescale 1ns/1ps
`default_nettype none
module lvdet_top
   import lvdet_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   // Host parallel port, indirect location already resolved.
   input  wire logic                 host_wr_en,
   input  wire logic                 host_rd_en,
   input  wire logic [ADDR_W-1:0]    host_addr,
   input  wire logic [DATA_W-1:0]    host_wdata,
   output logic [DATA_W-1:0]         host_rdata,
   output logic                      host_rvalid,
   // Level detector sample path.
   input  wire logic [15:0]          det_sample,
   input  wire logic                 det_sample_en,
   input  wire logic                 det_src_is_test,
   input  wire logic                 gated_interp_sel,
   output logic                      level_done,
   // Test input bus, per channel enable selection.
   input  wire logic [NUM_CH-1:0]    ch_en_bit,
   input  wire logic [NUM_CH-1:0]    ch_strobe_sel,
   output logic [15:0]               test_input_value,
   output logic [NUM_CH-1:0]         channel_sample_enable,
   // Sync.
   input  wire logic                 sync_input_pin,
   output logic                      sync_output_pin,
   output logic                      sync_event,
   // Self-test.
   input  wire logic [15:0]          bist_signature,
   input  wire logic                 bist_done,
   output logic                      bist_match,
   // FIFO read order.
   input  wire logic [3:0][23:0]     ch_i,
   input  wire logic [3:0][23:0]     ch_q,
   input  wire logic [3:0][23:0]     ch_mag,
   input  wire logic [3:0][15:0]     ch_phase,
   input  wire logic [3:0][15:0]     ch_gain,
   input  wire logic [4:0]           fifo_slot,
   output logic [15:0]               fifo_word
);

   typedef struct packed {
      logic [CFG_W-1:0]  cfg;
      logic [15:0]       test_val;
      logic [15:0]       sig_exp;
      logic [15:0]       sig_got;
      logic              start;
      logic              test_strobe;
      logic              sync_out;
      logic              sync_loop;
      logic              sync_m1;
      logic              sync_m2;
      logic [DATA_W-1:0] rdata;
      logic              rvalid;
   } lvdet_top_state_t;

   lvdet_top_state_t s_q, s_d;

   logic        wr_cfg;
   logic        wr_start;
   logic        wr_test;
   logic        wr_test_en;
   logic        wr_sync;
   logic        wr_loop;
   logic        wr_sig;
   logic        wr_order;
   logic        rd_order;
   logic [4:0]  order_idx;
   logic [4:0]  order_code;
   logic [31:0] level_result;
   logic [15:0] det_in;
   logic [DATA_W-1:0] rd_mux;

   // Address decode; each location owns one exact address.
   always_comb begin
      wr_cfg     = 1'b0;
      wr_start   = 1'b0;
      wr_test    = 1'b0;
      wr_test_en = 1'b0;
      wr_sync    = 1'b0;
      wr_loop    = 1'b0;
      wr_sig     = 1'b0;
      wr_order   = 1'b0;
      rd_order   = 1'b0;
      if (host_addr == ADDR_CONFIG) begin
         wr_cfg = host_wr_en;
      end else if (host_addr == ADDR_START) begin
         wr_start = host_wr_en;
      end else if (host_addr == ADDR_TEST_VALUE) begin
         wr_test = host_wr_en;
      end else if (host_addr == ADDR_TEST_EN) begin
         wr_test_en = host_wr_en;
      end else if (host_addr == ADDR_SYNC_OUT) begin
         wr_sync = host_wr_en;
      end else if (host_addr == ADDR_SYNC_LOOP) begin
         wr_loop = host_wr_en;
      end else if (host_addr == ADDR_SIGNATURE) begin
         wr_sig = host_wr_en;
      end else if (host_addr >= ADDR_ORDER_BASE && host_addr <= ADDR_ORDER_LAST) begin
         wr_order = host_wr_en;
         rd_order = 1'b1;
      end
   end

   assign order_idx = host_addr[4:0];

   // Read data; unmapped and write-only locations read as zero.
   always_comb begin
      rd_mux = '0;
      if (host_addr == ADDR_CONFIG) begin
         rd_mux = {10'h000, s_q.cfg};
      end else if (host_addr == ADDR_START) begin
         rd_mux = level_result;
      end else if (host_addr == ADDR_TEST_VALUE) begin
         rd_mux = {16'h0000, s_q.test_val};
      end else if (host_addr == ADDR_SIGNATURE) begin
         rd_mux = {s_q.sig_got, s_q.sig_exp};
      end else if (rd_order) begin
         rd_mux = {27'h0000000, order_code};
      end
   end

   always_comb begin
      s_d = s_q;
      if (wr_cfg) begin
         // Bits 31:22 are not stored; the host is told to write zeros there.
         s_d.cfg = host_wdata[CFG_W-1:0];
      end
      if (wr_test) begin
         s_d.test_val = host_wdata[15:0];
      end
      if (wr_sig) begin
         s_d.sig_exp = host_wdata[15:0];
      end
      if (bist_done) begin
         s_d.sig_got = bist_signature;
      end
      // Strobes are registered so each write gives exactly one clock of pulse.
      s_d.start       = wr_start;
      s_d.test_strobe = wr_test_en;
      s_d.sync_out    = wr_sync || wr_loop;
      s_d.sync_loop   = wr_loop;
      s_d.sync_m1     = sync_input_pin;
      s_d.sync_m2     = s_q.sync_m1;
      s_d.rdata       = host_rd_en ? rd_mux : s_q.rdata;
      s_d.rvalid      = host_rd_en;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q          <= '0;
         s_q.cfg      <= CFG_RESET;
         s_q.test_val <= TEST_RESET;
         s_q.sig_exp  <= SIG_RESET;
         s_q.sig_got  <= SIG_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Per channel, the test bus enable is either the channel's static bit or the host strobe.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch_en
         assign channel_sample_enable[gi] = ch_strobe_sel[gi] ? s_q.test_strobe
                                                              : ch_en_bit[gi];
      end
   endgenerate

   // The test value can stand in for the detector sample; a constant saves power.
   assign det_in = det_src_is_test ? s_q.test_val : det_sample;

   lvdet_level_det u_level_det (
      .ref_clk          (ref_clk),
      .rst_b            (rst_b),
      .sample           (det_in),
      .sample_en        (det_sample_en),
      .gated_interp_sel (gated_interp_sel),
      .cfg              (s_q.cfg),
      .start            (s_q.start),
      .level_result     (level_result),
      .level_done       (level_done)
   );

   lvdet_fifo_order u_fifo_order (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .wr_en     (wr_order),
      .wr_idx    (order_idx),
      .wr_code   (host_wdata[4:0]),
      .rd_idx    (order_idx),
      .ch_i      (ch_i),
      .ch_q      (ch_q),
      .ch_mag    (ch_mag),
      .ch_phase  (ch_phase),
      .ch_gain   (ch_gain),
      .fifo_slot (fifo_slot),
      .rd_code   (order_code),
      .fifo_word (fifo_word)
   );

   assign test_input_value = s_q.test_val;
   assign sync_output_pin  = s_q.sync_out;
   // External pin after two stages, or the internal loopback of the same pulse.
   // Up to two board registers may delay the pin before it returns here.
   assign sync_event       = s_q.sync_m2 || s_q.sync_loop;
   assign bist_match       = (s_q.sig_got == s_q.sig_exp);
   assign host_rdata       = s_q.rdata;
   assign host_rvalid      = s_q.rvalid;

endmodule : lvdet_top
`default_nettype wire

/* File: tb/lvdet_chk.sv */
// Checker for the global control bank, bound to lvdet_top.
// Assumes every port of the bank is on ref_clk with rst_b as its reset.
`timescale 1ns/1ps
`default_nettype none
module lvdet_chk
   import lvdet_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              rst_b,
   input wire logic              host_wr_en,
   input wire logic              host_rd_en,
   input wire logic [ADDR_W-1:0] host_addr,
   input wire logic [DATA_W-1:0] host_rdata,
   input wire logic              host_rvalid,
   input wire logic              level_done,
   input wire logic [NUM_CH-1:0] ch_en_bit,
   input wire logic [NUM_CH-1:0] ch_strobe_sel,
   input wire logic [NUM_CH-1:0] channel_sample_enable,
   input wire logic              sync_input_pin,
   input wire logic              sync_output_pin,
   input wire logic              sync_event
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire logic wr_start = host_wr_en && host_addr == ADDR_START;
   wire logic wr_sync  = host_wr_en && host_addr == ADDR_SYNC_OUT;
   wire logic wr_loop  = host_wr_en && host_addr == ADDR_SYNC_LOOP;
   wire logic wr_ten   = host_wr_en && host_addr == ADDR_TEST_EN;
   property p_sync_pulse;
      wr_sync |=> sync_output_pin ##1 !sync_output_pin;
   endproperty
   a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse width wrong");
   property p_loop;
      wr_loop |=> sync_output_pin && sync_event;
   endproperty
   a_loop: assert property (p_loop) else $error("loopback pulse missing");
   property p_strobe;
      wr_ten |=> channel_sample_enable == (ch_strobe_sel | ch_en_bit);
   endproperty
   a_strobe: assert property (p_strobe) else $error("enable strobe missing");
   property p_no_strobe;
      !$past(wr_ten) |-> channel_sample_enable == (ch_en_bit & ~ch_strobe_sel);
   endproperty
   a_no_strobe: assert property (p_no_strobe) else $error("static enable wrong");
   property p_rvalid;
      1'b1 |-> host_rvalid == $past(host_rd_en);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
   property p_cfg_pad;
      host_rd_en && host_addr == ADDR_CONFIG |=> host_rdata[31:22] == 10'h000;
   endproperty
   a_cfg_pad: assert property (p_cfg_pad) else $error("config pad bits not zero");
   property p_start_clr;
      wr_start |-> ##2 !level_done;
   endproperty
   a_start_clr: assert property (p_start_clr) else $error("start did not clear done");
   property p_done_hold;
      level_done && !wr_start && !$past(wr_start) |=> level_done;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done dropped without start");
   property p_sync_in;
      $rose(sync_input_pin) |-> ##2 sync_event;
   endproperty
   a_sync_in: assert property (p_sync_in) else $error("sync input not seen");
   c_done: cover property ($rose(level_done));
   c_loop: cover property (wr_loop);
   c_event: cover property ($rose(sync_input_pin) ##2 sync_event);
endmodule : lvdet_chk
bind lvdet_top lvdet_chk lvdet_chk_i (.ref_clk, .rst_b, .host_wr_en, .host_rd_en, .host_addr, .host_rdata,
   .host_rvalid, .level_done, .ch_en_bit, .ch_strobe_sel, .channel_sample_enable, .sync_input_pin,
   .sync_output_pin, .sync_event);
`default_nettype wire

/* File: tb/lvdet_host.sv */
// Host processor model: parallel port accesses and the external sync loop.
// Assumes the bank takes a request at the edge where the enable is high.
`timescale 1ns/1ps
`default_nettype none
module lvdet_host (
   input  wire logic  ref_clk,
   input  wire logic  sync_output_pin,
   output logic       sync_input_pin,
   output logic       host_wr_en,
   output logic       host_rd_en,
   output logic [15:0] host_addr,
   output logic [31:0] host_wdata
);
   logic [1:0] pipe_q = 2'h0;
   initial begin
      host_wr_en = 1'b0;
      host_rd_en = 1'b0;
      host_addr = 16'h0000;
      host_wdata = 32'h0;
   end
   // Two board registers between the sync output and the sync input.
   always @(posedge ref_clk) pipe_q <= {pipe_q[0], sync_output_pin};
   assign sync_input_pin = pipe_q[1];
   task automatic acc(logic rd, logic [15:0] a, logic [31:0] d);
      @(posedge ref_clk);
      host_wr_en <= !rd;
      host_rd_en <= rd;
      host_addr <= a;
      host_wdata <= d;
      @(posedge ref_clk);
      host_wr_en <= 1'b0;
      host_rd_en <= 1'b0;
      // Idle bus lines carry junk, so nothing may lean on stale values.
      host_addr <= ~a;
      host_wdata <= ~d;
   endtask : acc
endmodule : lvdet_host
`default_nettype wire

/* File: tb/test_level_detector_global_strobes.sv */
// Self-checking bench: register bank, level detector, strobes, signature, read order.
// Assumes lvdet_host drives the host port; read answers are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module test_level_detector_global_strobes import lvdet_pkg::*;;
   logic ref_clk = 1'b0, rst_b = 1'b0, host_wr_en, host_rd_en, sync_input_pin, host_rvalid, level_done;
   logic sync_output_pin, sync_event, bist_match, bist_done = 1'b0;
   logic det_sample_en = 1'b0, det_src_is_test = 1'b0, gated_interp_sel = 1'b0;
   logic [15:0] host_addr, test_input_value, fifo_word, det_sample = 16'h0000, bist_signature = 16'h0000;
   logic [31:0] host_wdata, host_rdata;
   logic [3:0] ch_en_bit = 4'h0, ch_strobe_sel = 4'h0, channel_sample_enable;
   logic [4:0] fifo_slot = 5'h00;
   logic [3:0][23:0] ch_i = '0, ch_q = '0, ch_mag = '0;
   logic [3:0][15:0] ch_phase = '0, ch_gain = '0;
   logic [31:0] exp_q[$];
   logic [5:0] dcfg[9] = '{6'h02, 6'h22, 6'h01, 6'h00, 6'h04, 6'h08, 6'h0C, 6'h03, 6'h12};
   int n_errors = 0, num_checks = 0;
   lvdet_top lvdet_top_i (.ref_clk, .rst_b, .host_wr_en, .host_rd_en, .host_addr, .host_wdata, .host_rdata,
      .host_rvalid, .det_sample, .det_sample_en, .det_src_is_test, .gated_interp_sel, .level_done, .ch_en_bit,
      .ch_strobe_sel, .test_input_value, .channel_sample_enable, .sync_input_pin, .sync_output_pin, .sync_event,
      .bist_signature, .bist_done, .bist_match, .ch_i, .ch_q, .ch_mag, .ch_phase, .ch_gain, .fifo_slot, .fifo_word);
   lvdet_host lvdet_host_i (.ref_clk, .sync_output_pin, .sync_input_pin, .host_wr_en, .host_rd_en, .host_addr,
      .host_wdata);
   initial forever #4 ref_clk = ~ref_clk;
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic wr(logic [15:0] a, logic [31:0] d);
      lvdet_host_i.acc(1'b0, a, d);
   endtask : wr
   task automatic rd(logic [15:0] a, logic [31:0] e);
      exp_q.push_back(e);
      lvdet_host_i.acc(1'b1, a, 32'h0);
   endtask : rd
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask : tick
   // Detector model: magnitude of the formatted sample, over interval plus two updates, or plus four with the free-run bit set.
   function automatic logic [31:0] lvl(logic [21:0] c, logic [15:0] x);
      longint a, s;
      a = 0;
      s = longint'($signed(c[21] ? ~x : x));
      if (s < 0) s = -s;
      for (int i = 0; i < int'(c[15:0]) + (c[20] ? 4 : 2); i++) begin
         case (c[17:16])
            2'h0: a = a + (((s << 16) - a) >>> (c[19:18] == 2'h0 ? 0 : 4 + 4 * c[19:18]));
            2'h1: if ((s << 16) > a) a = s << 16;
            2'h2: a = a + s;
            default: ;
         endcase
      end
      return a[31:0];
   endfunction : lvl
   function automatic logic [15:0] fword(logic [4:0] c);
      case (c[2:0])
         DT_I_HI: return ch_i[c[4:3]][23:8];
         DT_I_LO: return {ch_i[c[4:3]][7:0], 8'h00};
         DT_Q_HI: return ch_q[c[4:3]][23:8];
         DT_Q_LO: return {ch_q[c[4:3]][7:0], 8'h00};
         DT_MAG_HI: return ch_mag[c[4:3]][23:8];
         DT_MAG_LO: return {ch_mag[c[4:3]][7:0], 8'h00};
         DT_PHASE: return ch_phase[c[4:3]];
         default: return ch_gain[c[4:3]];
      endcase
   endfunction : fword
   always @(posedge ref_clk) begin
      if (host_rvalid === 1'b1) chk("read data", host_rdata, exp_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("watchdog expired");
      print_verdict();
   end
   initial begin
      logic [31:0] w;
      logic [21:0] c;
      logic [15:0] x;
      void'($urandom(32'h413C8EB8));
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(ADDR_CONFIG, {10'h000, CFG_RESET});
      rd(ADDR_TEST_VALUE, {16'h0000, TEST_RESET});
      rd(ADDR_ORDER_LAST, {27'h0, SLOT_RESET});
      w = $urandom();
      wr(ADDR_CONFIG, w);
      rd(ADDR_CONFIG, {10'h000, w[21:0]});
      wr(ADDR_TEST_VALUE, w);
      rd(ADDR_TEST_VALUE, {16'h0000, w[15:0]});
      chk("test value", {16'h0000, test_input_value}, {16'h0000, w[15:0]});
      wr(16'hF800, w);
      rd(16'hF800, 32'h0);
      $display("test registers finished");
      // Integrator rows other than 6'h12 keep the free-run bit low so the interval ends them.
      foreach (dcfg[k]) begin
         c = {dcfg[k], 16'h0003};
         x = 16'($urandom_range(1, 32766));
         wr(ADDR_CONFIG, {10'h000, c});
         wr(ADDR_START, $urandom());
         tick();
         chk("done after start", {31'h0, level_done}, 32'h0);
         for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            det_sample <= x;
            det_sample_en <= 1'b1;
            @(posedge ref_clk);
            det_sample <= ~x;
            det_sample_en <= 1'b0;
            tick();
            if (i >= 3) chk("level done", {31'h0, level_done}, {31'h0, i > 3});
         end
         wr(ADDR_CONFIG, {10'h000, c & ~22'h100000});
         rd(ADDR_START, lvl(c, x));
      end
      wr(ADDR_CONFIG, 32'h0002_0003);
      // The test value stands in for the pin sample here, so the pin carries a wrong value on purpose.
      wr(ADDR_TEST_VALUE, {16'h0000, x});
      gated_interp_sel <= 1'b1;
      det_src_is_test <= 1'b1;
      det_sample <= ~x;
      wr(ADDR_START, 32'h0);
      @(posedge ref_clk);
      det_sample_en <= 1'b1;
      @(posedge ref_clk);
      det_sample_en <= 1'b0;
      repeat (8) tick();
      chk("interp done", {31'h0, level_done}, 32'h1);
      rd(ADDR_START, {16'h0000, x});
      $display("test detector finished");
      repeat (4) begin
         ch_en_bit <= 4'($urandom());
         ch_strobe_sel <= 4'($urandom());
         wr(ADDR_TEST_EN, $urandom());
         #1 chk("enable strobe", {28'h0, channel_sample_enable}, {28'h0, ch_strobe_sel | ch_en_bit});
         tick();
         chk("enable level", {28'h0, channel_sample_enable}, {28'h0, ch_en_bit & ~ch_strobe_sel});
      end
      wr(ADDR_SYNC_OUT, $urandom());
      #1 chk("sync out", {30'h0, sync_output_pin, sync_event}, 32'h2);
      tick();
      chk("sync out end", {30'h0, sync_output_pin, sync_event}, 32'h0);
      repeat (6) tick();
      wr(ADDR_SYNC_LOOP, $urandom());
      #1 chk("sync loop", {30'h0, sync_output_pin, sync_event}, 32'h3);
      tick();
      chk("sync loop end", {30'h0, sync_output_pin, sync_event}, 32'h0);
      $display("test strobes finished");
      x = 16'($urandom());
      wr(ADDR_SIGNATURE, {16'hFFFF, x});
      for (int i = 0; i < 2; i++) begin
         bist_signature <= i ? ~x : x;
         bist_done <= 1'b1;
         @(posedge ref_clk);
         bist_done <= 1'b0;
         tick();
         chk("signature match", {31'h0, bist_match}, {31'h0, i == 0});
         rd(ADDR_SIGNATURE, {i ? ~x : x, x});
      end
      ch_i <= {$urandom(), $urandom(), $urandom()};
      ch_q <= {$urandom(), $urandom(), $urandom()};
      ch_mag <= {$urandom(), $urandom(), $urandom()};
      ch_phase <= {$urandom(), $urandom()};
      ch_gain <= {$urandom(), $urandom()};
      for (int s = 0; s < 32; s++) begin
         wr(ADDR_ORDER_BASE + 16'(s), {27'($urandom()), 5'(s)});
         rd(ADDR_ORDER_BASE + 16'(s), 32'(s));
         fifo_slot <= 5'(s);
         repeat (2) tick();
         chk("fifo word", {16'h0000, fifo_word}, {16'h0000, fword(5'(s))});
      end
      $display("test signature and order finished");
      repeat (3) tick();
      print_verdict();
   end
endmodule : test_level_detector_global_strobes
`default_nettype wire
